// File: core/ewgr_regs.vh
// Constants for the EEPROM write guard and refresh request block
`ifndef EWGR_REGS_VH
`define EWGR_REGS_VH

// ----------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------
`define EWGR_OFF_CTRL 4'h0
`define EWGR_OFF_STAT 4'h4

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define EWGR_CTRL_PAR_BIT 0
`define EWGR_CTRL_RST 8'h00

// ----------------------------------------------------------------
// Serial opcodes
// ----------------------------------------------------------------
`define EWGR_CMD_LATCH_SET 8'h06
`define EWGR_CMD_LATCH_CLR 8'h04
`define EWGR_CMD_STAT_RD 8'h05
`define EWGR_CMD_STAT_WR 8'h01
`define EWGR_CMD_ARR_RD 8'h03
`define EWGR_CMD_ARR_WR 8'h02

// ----------------------------------------------------------------
// Status byte field positions and reset value
// ----------------------------------------------------------------
`define EWGR_SB_BUSY 0
`define EWGR_SB_LATCH 1
`define EWGR_SB_GLO 2
`define EWGR_SB_GHI 3
`define EWGR_SB_PEN 7
`define EWGR_STAT_RST 8'h00

// ----------------------------------------------------------------
// Timing figures in their own units
// ----------------------------------------------------------------
`define EWGR_CLK_HZ 50000000
`define EWGR_WRCYC_MS 90
`define EWGR_PWRUP_S 20
`define EWGR_PERIOD_DAYS 30
`define EWGR_REFRESH_S 45
`define EWGR_LOAD_US 100

`endif

// File: core/ewgr_core.v
// Write guard, serial command front end and refresh request logic
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
`include "ewgr_regs.vh"

// Operation
// - Latch clear refuses every write
// - Pin enabled and low: unguarded only, no status
// - Pin high with latch: unguarded and status
// - Guard bits select none, quarter, half, all
// - Guarded addresses stay readable, never written
// - Guard bits change only by status write
// - Refresh request every thirty days periodically
// - Refresh request held twenty seconds at power-up
// - Full refresh takes about forty-five seconds
// - Data line six toggles per read while busy
// - Serial port works in clock modes 0 and 3
// - Only set command sets latch, clear clears
// - Latch clears when write cycle completes
// - Guard and enable bits kept nonvolatile
module ewgr_core #(
    parameter [31:0] P_WCYC = `EWGR_WRCYC_MS * (`EWGR_CLK_HZ / 1000),
    parameter [31:0] P_PWRUP = `EWGR_PWRUP_S * `EWGR_CLK_HZ,
    parameter [31:0] P_REFRESH = `EWGR_REFRESH_S * 32'd50000000,
    parameter [47:0] P_PERIOD = `EWGR_PERIOD_DAYS * 48'd86400
        * `EWGR_CLK_HZ,
    parameter [31:0] P_LOAD = `EWGR_LOAD_US * (`EWGR_CLK_HZ / 1000000)
)
(
    input wire i_sys_clk,
    input wire i_nrst,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire i_cs_n,
    input wire i_sck,
    input wire i_mosi,
    output reg o_miso,
    output reg o_miso_oe,
    input wire i_protect_pin_n,
    input wire i_par_we_n,
    input wire i_par_oe_n,
    input wire [14:0] i_par_addr,
    input wire [7:0] i_par_data,
    output reg o_toggle6,
    input wire i_refresh_ack_n,
    output reg o_refresh_request_n,
    input wire [7:0] i_nv_status,
    output reg o_nv_wr,
    output reg [7:0] o_nv_data,
    output reg o_arr_wr,
    output reg [14:0] o_arr_addr,
    output reg [7:0] o_arr_data
);

    // ----------------------------------------------------------------
    // Refresh sequencer states
    // ----------------------------------------------------------------
    localparam [1:0] RF_HOLD = 2'b00;
    localparam [1:0] RF_IDLE = 2'b01;
    localparam [1:0] RF_RUN = 2'b10;

    // ----------------------------------------------------------------
    // Guard decode, used by serial and parallel writes
    // ----------------------------------------------------------------
    // Returns 1 when the address lies in the guarded range
    function guarded;
        input [1:0] g;
        input [14:0] a;
        begin
            case (g)
                2'b00: guarded = 1'b0;
                2'b01: guarded = (a[14:13] == 2'b11);
                2'b10: guarded = a[14];
                default: guarded = 1'b1;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Order: ack_n, oe_n, we_n, mosi, sck, cs_n
    reg [5:0] pin_s1_reg; // First stage, read only by second
    reg [5:0] pin_s2_reg; // Stable copy
    reg [5:0] pin_s3_reg; // Previous copy for edge finding
    reg [23:0] bus_s1_reg; // Parallel address, data, protect pin
    reg [23:0] bus_s2_reg;

    // Two flops before any logic sees a pin
    always @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pin_s1_reg <= 6'h3F;
            pin_s2_reg <= 6'h3F;
            pin_s3_reg <= 6'h3F;
            bus_s1_reg <= 24'hFFFFFF;
            bus_s2_reg <= 24'hFFFFFF;
        end
        else
        begin
            pin_s1_reg <= {i_refresh_ack_n, i_par_oe_n, i_par_we_n,
                           i_mosi, i_sck, i_cs_n};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            bus_s1_reg <= {i_protect_pin_n, i_par_addr, i_par_data};
            bus_s2_reg <= bus_s1_reg;
        end
    end

    wire cs_low = ~pin_s2_reg[0];
    wire cs_rise = pin_s2_reg[0] & ~pin_s3_reg[0];
    // Both clock modes sample on the rising edge, shift on falling
    wire sck_rise = pin_s2_reg[1] & ~pin_s3_reg[1] & cs_low;
    wire sck_fall = ~pin_s2_reg[1] & pin_s3_reg[1] & cs_low;
    wire mosi = pin_s2_reg[2];
    wire we_fall = ~pin_s2_reg[3] & pin_s3_reg[3];
    wire oe_fall = ~pin_s2_reg[4] & pin_s3_reg[4];
    wire ack_fall = ~pin_s2_reg[5] & pin_s3_reg[5];
    wire pin_high = bus_s2_reg[23];

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    reg [7:0] ctrl_reg; // Software control, bit 0 selects parallel
    reg latch_reg; // write_latch_flag
    reg [1:0] guard_reg; // block_guard_hi, block_guard_lo
    reg pen_reg; // pin_guard_enable
    reg nv_done_reg; // Nonvolatile bits fetched after reset
    reg busy_reg; // Internal write cycle running
    reg [31:0] wcnt_reg; // Write cycle timer
    reg stat_pend_reg; // Cycle will commit a status byte
    reg [7:0] stat_new_reg; // Status byte waiting for commit
    reg loading_reg; // Parallel page load window open
    reg [31:0] lcnt_reg; // Time since last parallel byte load
    reg [7:0] op_reg; // Serial opcode of this frame
    reg [7:0] sh_reg; // Serial shift register
    reg [2:0] bit_reg; // Bit within current byte
    reg [2:0] byte_reg; // Bytes seen, saturates at 4
    reg [14:0] sa_reg; // Serial address pointer
    reg wrote_reg; // Frame accepted at least one data byte
    reg [1:0] rf_state_reg; // Refresh sequencer state
    reg [47:0] rf_cnt_reg; // Refresh timer

    // Status write gating, port mode, cycle end and serial byte decode
    wire stat_ok = latch_reg & ~(pen_reg & ~pin_high);
    wire par_mode = ctrl_reg[`EWGR_CTRL_PAR_BIT];
    wire cycle_end = busy_reg & (wcnt_reg == P_WCYC - 32'd1);
    wire nb_done = sck_rise & (bit_reg == 3'd7);
    wire [7:0] nb = {sh_reg[6:0], mosi};

    // Status byte as shifted out; only busy shows during a cycle
    wire [7:0] stat_view = busy_reg ? 8'h01 :
        {pen_reg, 3'b000, guard_reg, latch_reg, 1'b0};

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    // Control write and read data one cycle after the strobe
    always @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ctrl_reg <= `EWGR_CTRL_RST;
            o_rdata <= 8'h00;
        end
        else
        begin
            if (i_wr && i_addr == `EWGR_OFF_CTRL)
                ctrl_reg <= i_wdata;
            if (i_rd)
            begin
                case (i_addr)
                    `EWGR_OFF_CTRL: o_rdata <= ctrl_reg;
                    `EWGR_OFF_STAT: o_rdata <= stat_view;
                    default: o_rdata <= 8'h00; // Unmapped reads zero
                endcase
            end
            else
                o_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Serial framing: shift in, count bits and bytes, shift out
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sh_reg <= 8'h00;
            bit_reg <= 3'd0;
            byte_reg <= 3'd0;
            op_reg <= 8'h00;
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
        end
        else if (!cs_low)
        begin
            // Deselected: restart framing, release the output
            bit_reg <= 3'd0;
            byte_reg <= 3'd0;
            o_miso_oe <= 1'b0;
        end
        else
        begin
            o_miso_oe <= 1'b1;
            if (sck_rise)
            begin
                sh_reg <= nb;
                bit_reg <= bit_reg + 3'd1;
                if (bit_reg == 3'd7 && byte_reg != 3'd4)
                    byte_reg <= byte_reg + 3'd1;
                if (bit_reg == 3'd7 && byte_reg == 3'd0)
                    op_reg <= nb;
            end
            // Status repeats MSB first after the opcode
            if (sck_fall && byte_reg != 3'd0
                && op_reg == `EWGR_CMD_STAT_RD)
                o_miso <= stat_view[3'd7 - bit_reg];
        end
    end

    // ----------------------------------------------------------------
    // Write guard, latch, write cycle and status commit
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            latch_reg <= 1'b0;
            guard_reg <= 2'b00;
            pen_reg <= 1'b0;
            nv_done_reg <= 1'b0;
            busy_reg <= 1'b0;
            wcnt_reg <= 32'd0;
            stat_pend_reg <= 1'b0;
            stat_new_reg <= `EWGR_STAT_RST;
            loading_reg <= 1'b0;
            lcnt_reg <= 32'd0;
            sa_reg <= 15'h0000;
            wrote_reg <= 1'b0;
            o_arr_wr <= 1'b0;
            o_arr_addr <= 15'h0000;
            o_arr_data <= 8'h00;
            o_nv_wr <= 1'b0;
            o_nv_data <= 8'h00;
            o_toggle6 <= 1'b0;
        end
        else
        begin
            o_arr_wr <= 1'b0;
            o_nv_wr <= 1'b0;
            // Fetch persistent bits once after reset release
            if (!nv_done_reg)
            begin
                nv_done_reg <= 1'b1;
                guard_reg <= {i_nv_status[`EWGR_SB_GHI],
                              i_nv_status[`EWGR_SB_GLO]};
                pen_reg <= i_nv_status[`EWGR_SB_PEN];
            end
            // Serial address and data bytes of an array write
            if (nb_done && op_reg == `EWGR_CMD_ARR_WR)
            begin
                if (byte_reg == 3'd1)
                    sa_reg[14:8] <= nb[6:0];
                else if (byte_reg == 3'd2)
                    sa_reg[7:0] <= nb;
                else if (byte_reg >= 3'd3)
                begin
                    // Page pointer wraps in its low six bits
                    sa_reg[5:0] <= sa_reg[5:0] + 6'd1;
                    // Guarded or disabled bytes vanish silently
                    if (latch_reg && !busy_reg
                        && !guarded(guard_reg, sa_reg))
                    begin
                        o_arr_wr <= 1'b1;
                        o_arr_addr <= sa_reg;
                        o_arr_data <= nb;
                        wrote_reg <= 1'b1;
                    end
                end
            end
            // Status write data byte, kept until the cycle end commits it
            if (nb_done && op_reg == `EWGR_CMD_STAT_WR
                && byte_reg == 3'd1)
                stat_new_reg <= nb;
            // Parallel byte load
            if (par_mode && we_fall && latch_reg && !busy_reg
                && !guarded(guard_reg, bus_s2_reg[22:8]))
            begin
                o_arr_wr <= 1'b1;
                o_arr_addr <= bus_s2_reg[22:8];
                o_arr_data <= bus_s2_reg[7:0];
                loading_reg <= 1'b1;
                lcnt_reg <= 32'd0;
            end
            else if (loading_reg)
            begin
                // Quiet load window closes the page and starts programming
                if (lcnt_reg == P_LOAD - 32'd1)
                begin
                    loading_reg <= 1'b0;
                    busy_reg <= 1'b1;
                    wcnt_reg <= 32'd0;
                end
                else
                    lcnt_reg <= lcnt_reg + 32'd1;
            end
            // Parallel read while busy flips data line six
            if (par_mode && oe_fall && busy_reg)
                o_toggle6 <= ~o_toggle6;
            // Deselect carries out the frame's command
            if (cs_rise)
            begin
                wrote_reg <= 1'b0;
                if (!busy_reg && byte_reg == 3'd1 && bit_reg == 3'd0)
                begin
                    if (op_reg == `EWGR_CMD_LATCH_SET)
                        latch_reg <= 1'b1;
                    else if (op_reg == `EWGR_CMD_LATCH_CLR)
                        latch_reg <= 1'b0;
                end
                if (!busy_reg && op_reg == `EWGR_CMD_STAT_WR
                    && byte_reg == 3'd2 && bit_reg == 3'd0
                    && stat_ok)
                begin
                    busy_reg <= 1'b1;
                    wcnt_reg <= 32'd0;
                    stat_pend_reg <= 1'b1;
                end
                if (!busy_reg && wrote_reg)
                begin
                    busy_reg <= 1'b1;
                    wcnt_reg <= 32'd0;
                end
            end
            // Self-timed cycle runs to its fixed length
            if (busy_reg)
                wcnt_reg <= wcnt_reg + 32'd1;
            if (cycle_end)
            begin
                busy_reg <= 1'b0;
                latch_reg <= 1'b0;
                if (stat_pend_reg)
                begin
                    // Guard bits move only on a status write commit
                    stat_pend_reg <= 1'b0;
                    guard_reg <= {stat_new_reg[`EWGR_SB_GHI],
                                  stat_new_reg[`EWGR_SB_GLO]};
                    pen_reg <= stat_new_reg[`EWGR_SB_PEN];
                    o_nv_wr <= 1'b1;
                    o_nv_data <= {stat_new_reg[7], 3'b000,
                                  stat_new_reg[3:2], 2'b00};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Refresh request sequencer
    // ----------------------------------------------------------------
    // One wide timer serves hold, refresh run and period; the period
    // restarts after a refresh so requests do not bunch up
    always @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            // Start at the last idle count so the power-up hold is as
            // long as a periodic hold
            rf_state_reg <= RF_IDLE;
            rf_cnt_reg <= P_PERIOD - 48'd1;
            o_refresh_request_n <= 1'b1;
        end
        else
        begin
            rf_cnt_reg <= rf_cnt_reg + 48'd1;
            case (rf_state_reg)
                RF_HOLD:
                begin
                    o_refresh_request_n <= 1'b0;
                    if (ack_fall)
                    begin
                        rf_state_reg <= RF_RUN;
                        rf_cnt_reg <= 48'd0;
                        o_refresh_request_n <= 1'b1;
                    end
                    else if (rf_cnt_reg == {16'h0000, P_PWRUP}
                             - 48'd1)
                    begin
                        rf_state_reg <= RF_IDLE;
                        rf_cnt_reg <= 48'd0;
                        o_refresh_request_n <= 1'b1;
                    end
                end
                RF_RUN:
                begin
                    o_refresh_request_n <= 1'b1;
                    if (rf_cnt_reg == {16'h0000, P_REFRESH} - 48'd1)
                    begin
                        rf_state_reg <= RF_IDLE;
                        rf_cnt_reg <= 48'd0;
                    end
                end
                RF_IDLE:
                begin
                    o_refresh_request_n <= 1'b1;
                    if (rf_cnt_reg == P_PERIOD - 48'd1)
                    begin
                        rf_state_reg <= RF_HOLD;
                        rf_cnt_reg <= 48'd0;
                        o_refresh_request_n <= 1'b0;
                    end
                end
                default:
                begin
                    rf_state_reg <= RF_IDLE;
                    rf_cnt_reg <= 48'd0;
                    o_refresh_request_n <= 1'b1;
                end
            endcase
        end
    end

endmodule

// File: core/ewgr_dummy_unused.v
// Holds no logic; the core file carries all of it

// File: verification/ewgr_core_chk.sv
// Port checker for the write guard and refresh request block
`timescale 1ns/1ns
`include "ewgr_regs.vh"
module ewgr_core_chk #(
    parameter [31:0] P_PWRUP = 32'h64,
    parameter [47:0] P_PERIOD = 48'h1F4
)
(
    input wire i_sys_clk,
    input wire i_nrst,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire i_cs_n,
    input wire o_miso_oe,
    input wire i_refresh_ack_n,
    input wire o_refresh_request_n,
    input wire [7:0] i_nv_status,
    input wire o_nv_wr,
    input wire [7:0] o_nv_data,
    input wire o_arr_wr,
    input wire [14:0] o_arr_addr
);
default clocking dc @(posedge i_sys_clk);
endclocking
default disable iff (!i_nrst);
// ------------------------------------------------------------
// Shadow state: request run lengths, guard bits, mode bit
// ------------------------------------------------------------
reg [31:0] low_cnt, high_cnt;
reg req_q, ack_hit, seen_low, fresh, par_q;
reg [1:0] guard_q;
always @(posedge i_sys_clk or negedge i_nrst)
begin
    if (!i_nrst)
    begin
        {low_cnt, high_cnt} <= 64'h0;
        {req_q, ack_hit, seen_low, fresh, par_q} <= 5'h12;
        guard_q <= 2'h0;
    end
    else
    begin
        low_cnt <= o_refresh_request_n ? 32'h0 : low_cnt + 32'h1;
        high_cnt <= o_refresh_request_n ? high_cnt + 32'h1 : 32'h0;
        req_q <= o_refresh_request_n;
        seen_low <= seen_low | ~o_refresh_request_n;
        // An acknowledge excuses the next hold and idle lengths
        ack_hit <= (ack_hit & ~(req_q & ~o_refresh_request_n))
            | (~o_refresh_request_n & ~i_refresh_ack_n);
        fresh <= 1'h0;
        if (fresh)
            guard_q <= i_nv_status[3:2];
        else if (o_nv_wr)
            guard_q <= o_nv_data[3:2];
        if (i_wr && i_addr == `EWGR_OFF_CTRL)
            par_q <= i_wdata[0];
    end
end
function automatic logic hit(input logic [1:0] g, input logic [14:0] a);
    hit = (g == 2'h3) || (g == 2'h2 && a[14]) || (g == 2'h1 && &a[14:13]);
endfunction
// ------------------------------------------------------------
// Properties
// ------------------------------------------------------------
sequence s_req_low;
    !o_refresh_request_n [*8];
endsequence
property p_pwrup;
    $rose(i_nrst) |-> ##1 s_req_low;
endproperty
property p_hold;
    $rose(o_refresh_request_n) |-> ack_hit || low_cnt == P_PWRUP;
endproperty
property p_idle;
    $fell(o_refresh_request_n) && seen_low && !ack_hit
        |-> high_cnt == P_PERIOD;
endproperty
property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
endproperty
property p_ctrl_rd;
    i_rd && i_addr == `EWGR_OFF_CTRL |=> o_rdata == {7'h00, par_q};
endproperty
property p_oe_off;
    i_cs_n [*4] |-> !o_miso_oe;
endproperty
property p_arr_pulse;
    o_arr_wr |=> !o_arr_wr;
endproperty
property p_guard;
    o_arr_wr |-> !hit(guard_q, o_arr_addr);
endproperty
a_pwrup: assert property (p_pwrup)
    else $error("request not held after reset");
a_hold: assert property (p_hold)
    else $error("request hold length wrong");
a_idle: assert property (p_idle)
    else $error("request idle length wrong");
a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside read");
a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control readback wrong");
a_oe_off: assert property (p_oe_off)
    else $error("serial output enabled while deselected");
a_arr_pulse: assert property (p_arr_pulse)
    else $error("array write pulse too long");
a_guard: assert property (p_guard)
    else $error("write reached a guarded address");
endmodule
bind ewgr_core ewgr_core_chk #(.P_PWRUP(P_PWRUP), .P_PERIOD(P_PERIOD))
    u_chk (.*);

// File: verification/ewgr_spi_host.sv
// Serial host model for the far side of the link
`timescale 1ns/1ns
module ewgr_spi_host
(
    input wire i_sys_clk,
    input wire i_miso,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_mosi
);
initial
begin
    o_cs_n = 1'h1;
    o_sck = 1'h0;
    o_mosi = 1'h0;
end
task automatic hold(input int n);
    repeat (n) @(posedge i_sys_clk);
endtask
// One frame, MSB first; clock stands still at idle outside frames
task automatic frame(input logic [31:0] tx, input int n, input logic m3,
    output logic [7:0] rx);
    rx = 8'h00;
    @(posedge i_sys_clk);
    o_sck <= m3;
    hold(4);
    o_cs_n <= 1'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
        hold(4);
        o_sck <= 1'h0;
        o_mosi <= tx[i];
        hold(4);
        o_sck <= 1'h1;
        hold(1);
        rx = {rx[6:0], i_miso};
        hold(3);
    end
    if (!m3)
    begin
        o_sck <= 1'h0;
        hold(4);
    end
    o_cs_n <= 1'h1;
    // Released line shows the inverse, never a stale bit
    o_mosi <= ~o_mosi;
    hold(8);
endtask
endmodule

// File: verification/test_ewgr_core.sv
// Self-checking bench for the write guard and refresh block
`timescale 1ns/1ns
`include "ewgr_regs.vh"
module test_ewgr_core;
localparam int WC = 50;
logic i_sys_clk = 1'h0, i_nrst = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
logic [3:0] i_addr = 4'h0;
logic [7:0] i_wdata = 8'h00, i_par_data = 8'h00, i_nv_status = 8'h00;
logic i_protect_pin_n = 1'h1, i_par_we_n = 1'h1, i_par_oe_n = 1'h1;
logic i_refresh_ack_n = 1'h1, rd_seen = 1'h0, m3 = 1'h0;
logic [14:0] i_par_addr = 15'h0000;
wire [7:0] o_rdata, o_nv_data, o_arr_data;
wire [14:0] o_arr_addr;
wire o_miso, o_miso_oe, o_toggle6, o_refresh_request_n, o_nv_wr;
wire o_arr_wr, i_cs_n, i_sck, i_mosi;
logic [25:0] exp_q[$];
int miscompares = 0, check_count = 0;
logic [31:0] seed = 32'h9AAF;
logic [7:0] rx;
logic [14:0] addrs [5] = '{15'h3FFF, 15'h4000, 15'h5FFF, 15'h6000, 15'h7FFF};
always #10 i_sys_clk = ~i_sys_clk;
ewgr_core #(.P_WCYC(32'h32), .P_PWRUP(32'h64), .P_REFRESH(32'h50),
    .P_PERIOD(48'h1F4), .P_LOAD(32'h14)) dut (.*);
ewgr_spi_host host (.i_sys_clk(i_sys_clk), .i_miso(o_miso),
    .o_cs_n(i_cs_n), .o_sck(i_sck), .o_mosi(i_mosi));
// ------------------------------------------------------------
// Helpers: cells, random bytes, compare, result watcher
// ------------------------------------------------------------
always @(posedge i_sys_clk)
begin
    rd_seen <= i_rd;
    if (o_nv_wr)
        i_nv_status <= o_nv_data;
end
function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
endfunction
task check(input string name, input logic [25:0] seen, input logic [25:0] e);
    check_count++;
    if (seen !== e)
    begin
        miscompares++;
        $display("Error %s expected %h seen %h", name, e, seen);
    end
endtask
task pop_cmp(input logic [25:0] seen);
    if (exp_q.size() == 0)
        check("unexpected output", seen, 26'h3FFFFFF);
    else
        check("output", seen, exp_q.pop_front());
endtask
always @(negedge i_sys_clk)
begin
    if (i_nrst && o_arr_wr)
        pop_cmp({2'h1, 1'h0, o_arr_addr, o_arr_data});
    if (i_nrst && o_nv_wr)
        pop_cmp({2'h2, 16'h0000, o_nv_data});
    if (i_nrst && rd_seen)
        pop_cmp({2'h0, 16'h0000, o_rdata});
end
task cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
endtask
task reg_acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= w;
    i_rd <= ~w;
    if (!w)
        exp_q.push_back({2'h0, 16'h0000, d});
    @(posedge i_sys_clk);
    {i_wr, i_rd} <= 2'h0;
endtask
task spi(input logic [31:0] tx, input int n);
    host.frame(tx, n, m3, rx);
    m3 = ~m3;
endtask
task stat_rd(input logic [7:0] e);
    spi({`EWGR_CMD_STAT_RD, 8'h00}, 16);
    check("status", {18'h0, rx}, {18'h0, e});
endtask
task wr_op(input logic [31:0] tx, input int n, input logic [25:0] e,
    input logic ok);
    spi(`EWGR_CMD_LATCH_SET, 8);
    if (ok)
        exp_q.push_back(e);
    spi(tx, n);
    cyc(WC + 10);
endtask
task arr_wr(input logic [14:0] a, input logic ok);
    logic [7:0] d;
    d = rnd();
    wr_op({`EWGR_CMD_ARR_WR, 1'h0, a, d}, 32, {2'h1, 1'h0, a, d}, ok);
endtask
task print_verdict;
    check("queue left", 26'(exp_q.size()), 26'h0);
    $display("Checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
initial
begin
    #(60000 * 20);
    miscompares++;
    $display("Error watchdog expired");
    print_verdict;
end
// ------------------------------------------------------------
// Main sequence
// ------------------------------------------------------------
initial
begin
    int k;
    logic [14:0] a;
    logic t;
    cyc(16);
    i_nrst <= 1'h1;
    cyc(4);
    reg_acc(1'h0, `EWGR_OFF_CTRL, `EWGR_CTRL_RST);
    reg_acc(1'h0, 4'h8, 8'h00);
    reg_acc(1'h1, `EWGR_OFF_CTRL, 8'h01);
    reg_acc(1'h0, `EWGR_OFF_CTRL, 8'h01);
    reg_acc(1'h1, `EWGR_OFF_STAT, 8'hFF);
    reg_acc(1'h0, `EWGR_OFF_STAT, `EWGR_STAT_RST);
    reg_acc(1'h1, `EWGR_OFF_CTRL, 8'h00);
    spi({`EWGR_CMD_ARR_WR, 24'h001055}, 32);
    cyc(WC + 10);
    spi(`EWGR_CMD_LATCH_SET, 8);
    stat_rd(8'h02);
    spi(`EWGR_CMD_LATCH_CLR, 8);
    stat_rd(8'h00);
    for (int g = 0; g < 4; g++)
    begin
        wr_op({`EWGR_CMD_STAT_WR, 4'h0, 2'(g), 2'h0}, 16,
            {2'h2, 16'h0, 4'h0, 2'(g), 2'h0}, 1'h1);
        for (k = 0; k < 5; k++)
        begin
            a = addrs[k];
            arr_wr(a, !(g == 3 || (g == 2 && a[14])
                || (g == 1 && &a[14:13])));
        end
    end
    stat_rd(8'h0E);
    wr_op({`EWGR_CMD_STAT_WR, 8'h80}, 16, {18'h2_0000, 8'h80}, 1'h1);
    i_protect_pin_n <= 1'h0;
    wr_op({`EWGR_CMD_STAT_WR, 8'h0C}, 16, 26'h0, 1'h0);
    arr_wr(15'h0100, 1'h1);
    stat_rd(8'h80);
    i_protect_pin_n <= 1'h1;
    i_nrst <= 1'h0;
    cyc(16);
    i_nrst <= 1'h1;
    cyc(4);
    stat_rd(8'h80);
    wr_op({`EWGR_CMD_STAT_WR, 8'h00}, 16, {2'h2, 24'h0}, 1'h1);
    reg_acc(1'h1, `EWGR_OFF_CTRL, 8'h01);
    spi(`EWGR_CMD_LATCH_SET, 8);
    for (k = 0; k < 2; k++)
    begin
        i_par_addr <= 15'h0200 + 15'(k);
        i_par_data <= rnd();
        cyc(2);
        exp_q.push_back({2'h1, 1'h0, i_par_addr, i_par_data});
        i_par_we_n <= 1'h0;
        cyc(5);
        i_par_we_n <= 1'h1;
        cyc(3);
    end
    cyc(30);
    for (k = 0; k < 3; k++)
    begin
        t = o_toggle6;
        i_par_oe_n <= 1'h0;
        cyc(6);
        i_par_oe_n <= 1'h1;
        @(negedge i_sys_clk);
        check("toggle", {25'h0, o_toggle6}, {25'h0, ~t});
        cyc(1);
    end
    cyc(WC + 10);
    reg_acc(1'h1, `EWGR_OFF_CTRL, 8'h00);
    for (k = 0; k < 2000 && o_refresh_request_n !== 1'h1; k++)
        @(negedge i_sys_clk);
    for (k = 0; k < 2000 && o_refresh_request_n !== 1'h0; k++)
        @(negedge i_sys_clk);
    check("request", {25'h0, o_refresh_request_n}, 26'h0);
    cyc(1);
    i_refresh_ack_n <= 1'h0;
    cyc(6);
    i_refresh_ack_n <= 1'h1;
    cyc(300);
    @(negedge i_sys_clk);
    check("request", {25'h0, o_refresh_request_n}, 26'h1);
    print_verdict;
end
endmodule
